// ---- hdl/amm_bank.sv ----
// Alarm and mute mask register bank with latched alarms, on APB
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module amm_bank (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [amm_pkg::AMM_ADDR_W-1:0] paddr_i,
	input wire logic [amm_pkg::AMM_DATA_W-1:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [amm_pkg::AMM_DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// FIFO level sources, one bit per bank
	input wire logic [amm_pkg::AMM_BANKS-1:0] fifo_enable_i,
	input wire logic [amm_pkg::AMM_BANKS-1:0] fifo_almost_empty_i,
	input wire logic [amm_pkg::AMM_BANKS-1:0] fifo_almost_full_i,
	// Interface sources, one bit per bank
	input wire logic [amm_pkg::AMM_BANKS-1:0] iface_clock_missing_i,
	input wire logic [amm_pkg::AMM_BANKS-1:0] strobe_position_err_i,
	// System sources, one-cycle events
	input wire logic trigger_divider_realign_i,
	input wire logic clock_misalignment_i,
	input wire logic clock_realignment_i,
	// Fuse controller and silicon version
	input wire logic fuse_done_i,
	input wire logic [amm_pkg::AMM_VER_W-1:0] chip_version_i,
	// Sync edge detector
	input wire logic sync_edge_i,
	input wire logic [amm_pkg::AMM_POS_W-1:0] sync_near_i,
	// Alarm and mute outputs
	output logic alarm_o,
	output logic dac_mute_o
);

	import amm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State and wires

	typedef struct packed {
		logic [AMM_REG_W-1:0] alarm_output_mask;
		logic [AMM_REG_W-1:0] output_mute_mask;
		logic [AMM_REG_W-1:0] sync_position_accumulate_ctrl;
		logic [AMM_DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
		logic alarm;
		logic mute;
	} amm_bank_state_t;

	amm_bank_state_t state_q;
	amm_bank_state_t state_d;

	logic [AMM_IDX_W-1:0] idx;
	logic access;
	logic commit;
	logic wr_commit;
	logic [AMM_REG_W-1:0] wbyte;
	logic hit;
	logic [AMM_REG_W-1:0] rbyte;

	logic [AMM_REG_W-1:0] fifo_level_alarm_bits;
	logic [AMM_REG_W-1:0] link_alarm_bits;
	logic [AMM_SYS_W-1:0] sys_alarm_bits;
	logic [AMM_REG_W-1:0] fifo_set;
	logic [AMM_REG_W-1:0] link_set;
	logic [AMM_SYS_W-1:0] sys_set;
	logic [AMM_REG_W-1:0] fifo_clr;
	logic [AMM_REG_W-1:0] link_clr;
	logic [AMM_SYS_W-1:0] sys_clr;

	logic [AMM_POS_W-1:0] sync_edge_position_record;
	logic sync_position_accumulate_enable;

	logic [AMM_BANKS-1:0] iface_clock_missing_alarm;
	logic [AMM_BANKS-1:0] strobe_position_alarm;
	logic trigger_divider_realign_alarm;
	logic clock_misalignment_alarm;
	logic clock_realignment_alarm;

	logic fifo_level_alarm_out_mask;
	logic iface_clock_alarm_out_mask;
	logic strobe_pos_alarm_out_mask;
	logic trigger_realign_alarm_out_mask;
	logic clock_misalign_alarm_out_mask;
	logic clock_realign_alarm_out_mask;
	logic fifo_mute_mask;
	logic iface_clock_mute_mask;
	logic strobe_mute_mask;
	logic trigger_realign_mute_mask;
	logic clock_misalign_mute_mask;
	logic clock_realign_mute_mask;

	////////////////////////////////////////////////////////////////////////////
	// Bus phase decode

	// Word index; answer comes one cycle into the access phase
	assign idx = paddr_i[AMM_ADDR_W-1:2];
	assign access = psel_i & penable_i;
	assign commit = access & state_q.pready;
	assign wr_commit = commit & pwrite_i & pstrb_i[AMM_STRB_LANE];
	assign wbyte = pwdata_i[AMM_REG_W-1:0];

	////////////////////////////////////////////////////////////////////////////
	// Alarm sources

	// Per-bank FIFO alarms: empty in the high nibble, full in the low
	genvar b;
	generate
		for (b = 0; b < AMM_BANKS; b++) begin : g_bank
			assign fifo_set[b+AMM_BANKS] = fifo_enable_i[b] & fifo_almost_empty_i[b];
			assign fifo_set[b] = fifo_enable_i[b] & fifo_almost_full_i[b];
			assign link_set[b+AMM_BANKS] = iface_clock_missing_i[b];
			assign link_set[b] = strobe_position_err_i[b];
		end
	endgenerate

	// System events in their status bit order
	assign sys_set[AMM_BIT_TRIG] = trigger_divider_realign_i;
	assign sys_set[AMM_BIT_MISALIGN] = clock_misalignment_i;
	assign sys_set[AMM_BIT_REALIGN] = clock_realignment_i;

	// Write-one-to-clear strobes, only at the committing edge
	assign fifo_clr = (wr_commit && idx == AMM_IDX_FIFO_LEVEL_ALARM_BITS) ? wbyte : '0;
	assign link_clr = (wr_commit && idx == AMM_IDX_LINK_ALM) ? wbyte : '0;
	assign sys_clr = (wr_commit && idx == AMM_IDX_SYS_ALM) ? wbyte[AMM_SYS_W-1:0] : '0;

	////////////////////////////////////////////////////////////////////////////
	// Latched alarms

	// FIFO level alarm bits
	amm_sticky #(
		.W(AMM_REG_W)
	) u_fifo_alarm (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.set_i(fifo_set),
		.clr_i(fifo_clr),
		.bits_o(fifo_level_alarm_bits)
	);

	// Interface clock and strobe alarm bits
	amm_sticky #(
		.W(AMM_REG_W)
	) u_link_alarm (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.set_i(link_set),
		.clr_i(link_clr),
		.bits_o(link_alarm_bits)
	);

	// System alignment alarm bits
	amm_sticky #(
		.W(AMM_SYS_W)
	) u_sys_alarm (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.set_i(sys_set),
		.clr_i(sys_clr),
		.bits_o(sys_alarm_bits)
	);

	// Named views of the latched bits
	assign iface_clock_missing_alarm = link_alarm_bits[AMM_REG_W-1:AMM_BANKS];
	assign strobe_position_alarm = link_alarm_bits[AMM_BANKS-1:0];
	assign trigger_divider_realign_alarm = sys_alarm_bits[AMM_BIT_TRIG];
	assign clock_misalignment_alarm = sys_alarm_bits[AMM_BIT_MISALIGN];
	assign clock_realignment_alarm = sys_alarm_bits[AMM_BIT_REALIGN];

	////////////////////////////////////////////////////////////////////////////
	// Sync edge position record

	// Control bit only counts on the silicon that has the function
	assign sync_position_accumulate_enable = state_q.sync_position_accumulate_ctrl[AMM_BIT_POS_EN]
		& (chip_version_i == AMM_PS_CHIP_VERSION);

	amm_pos_record #(
		.POS_W(AMM_POS_W)
	) u_pos_record (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.accum_en_i(sync_position_accumulate_enable),
		.edge_i(sync_edge_i),
		.near_i(sync_near_i),
		.record_o(sync_edge_position_record)
	);

	////////////////////////////////////////////////////////////////////////////
	// Mask fields

	// Alarm output masks
	assign fifo_level_alarm_out_mask = state_q.alarm_output_mask[AMM_BIT_FIFO];
	assign iface_clock_alarm_out_mask = state_q.alarm_output_mask[AMM_BIT_IFCLK];
	assign strobe_pos_alarm_out_mask = state_q.alarm_output_mask[AMM_BIT_STROBE];
	assign trigger_realign_alarm_out_mask = state_q.alarm_output_mask[AMM_BIT_TRIG];
	assign clock_misalign_alarm_out_mask = state_q.alarm_output_mask[AMM_BIT_MISALIGN];
	assign clock_realign_alarm_out_mask = state_q.alarm_output_mask[AMM_BIT_REALIGN];

	// Mute masks
	assign fifo_mute_mask = state_q.output_mute_mask[AMM_BIT_FIFO];
	assign iface_clock_mute_mask = state_q.output_mute_mask[AMM_BIT_IFCLK];
	assign strobe_mute_mask = state_q.output_mute_mask[AMM_BIT_STROBE];
	assign trigger_realign_mute_mask = state_q.output_mute_mask[AMM_BIT_TRIG];
	assign clock_misalign_mute_mask = state_q.output_mute_mask[AMM_BIT_MISALIGN];
	assign clock_realign_mute_mask = state_q.output_mute_mask[AMM_BIT_REALIGN];

	////////////////////////////////////////////////////////////////////////////
	// Read decode

	// Selected register byte and whether the index is mapped
	always_comb begin
		hit = 1'b1;
		rbyte = '0;
		case (idx)
			AMM_IDX_FIFO_LEVEL_ALARM_BITS: begin
				rbyte = fifo_level_alarm_bits;
			end
			AMM_IDX_LINK_ALM: begin
				rbyte = link_alarm_bits;
			end
			AMM_IDX_SYS_ALM: begin
				rbyte[AMM_SYS_W-1:0] = sys_alarm_bits;
			end
			AMM_IDX_ALARM_OUTPUT_MASK: begin
				rbyte = state_q.alarm_output_mask;
			end
			AMM_IDX_MUTE_MASK: begin
				rbyte = state_q.output_mute_mask;
			end
			AMM_IDX_FUSE_STAT: begin
				rbyte[AMM_BIT_FUSE_DONE] = fuse_done_i;
			end
			AMM_IDX_POS_CTRL: begin
				rbyte = state_q.sync_position_accumulate_ctrl;
			end
			AMM_IDX_POS_REC: begin
				rbyte = sync_edge_position_record;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		state_d = state_q;

		// One wait state, then answer; data and error stand one cycle
		state_d.pready = access & ~state_q.pready;
		state_d.prdata = '0;
		state_d.pslverr = 1'b0;
		if (access && !state_q.pready) begin
			state_d.pslverr = ~hit;
			if (!pwrite_i) begin
				state_d.prdata[AMM_REG_W-1:0] = rbyte;
			end
		end

		// Writes land at the committing edge; fuse status and position record ignore them, latched alarms clear through the strobes above
		if (wr_commit) begin
			case (idx)
				AMM_IDX_ALARM_OUTPUT_MASK: begin
					state_d.alarm_output_mask = wbyte;
				end
				AMM_IDX_MUTE_MASK: begin
					state_d.output_mute_mask = wbyte;
				end
				AMM_IDX_POS_CTRL: begin
					// Bits 7-1 are stored as written; software keeps them zero
					state_d.sync_position_accumulate_ctrl = wbyte;
				end
				default: begin
					state_d.alarm_output_mask = state_q.alarm_output_mask;
				end
			endcase
		end

		// Alarm output from latched alarms whose output mask is clear
		state_d.alarm = ((|fifo_level_alarm_bits) & ~fifo_level_alarm_out_mask)
			| ((|iface_clock_missing_alarm) & ~iface_clock_alarm_out_mask)
			| ((|strobe_position_alarm) & ~strobe_pos_alarm_out_mask)
			| (trigger_divider_realign_alarm & ~trigger_realign_alarm_out_mask)
			| (clock_misalignment_alarm & ~clock_misalign_alarm_out_mask)
			| (clock_realignment_alarm & ~clock_realign_alarm_out_mask);

		// Mute while any latched alarm with a clear mute mask stands
		state_d.mute = ((|fifo_level_alarm_bits) & ~fifo_mute_mask)
			| ((|iface_clock_missing_alarm) & ~iface_clock_mute_mask)
			| ((|strobe_position_alarm) & ~strobe_mute_mask)
			| (trigger_divider_realign_alarm & ~trigger_realign_mute_mask)
			| (clock_misalignment_alarm & ~clock_misalign_mute_mask)
			| (clock_realignment_alarm & ~clock_realign_mute_mask);
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q.alarm_output_mask <= AMM_RST_ALARM_OUTPUT_MASK;
			state_q.output_mute_mask <= AMM_RST_MUTE_MASK;
			state_q.sync_position_accumulate_ctrl <= AMM_RST_POS_CTRL;
			state_q.prdata <= '0;
			state_q.pready <= 1'b0;
			state_q.pslverr <= 1'b0;
			state_q.alarm <= 1'b0;
			state_q.mute <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all registered

	assign prdata_o = state_q.prdata;
	assign pready_o = state_q.pready;
	assign pslverr_o = state_q.pslverr;
	assign alarm_o = state_q.alarm;
	assign dac_mute_o = state_q.mute;

endmodule
`default_nettype wire

// ---- hdl/amm_pkg.sv ----
// Constants shared by the alarm, mute mask and status register bank
package amm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Bus and register widths
	localparam int AMM_DATA_W = 32;
	localparam int AMM_ADDR_W = 14;
	localparam int AMM_IDX_W = 12;
	localparam int AMM_REG_W = 8;
	localparam int AMM_BANKS = 4;
	localparam int AMM_SYS_W = 3;
	localparam int AMM_POS_W = 8;
	localparam int AMM_VER_W = 4;

	////////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [11:0] AMM_IDX_FIFO_LEVEL_ALARM_BITS = 12'h820;
	localparam logic [11:0] AMM_IDX_LINK_ALM = 12'h821;
	localparam logic [11:0] AMM_IDX_SYS_ALM = 12'h822;
	localparam logic [11:0] AMM_IDX_ALARM_OUTPUT_MASK = 12'h823;
	localparam logic [11:0] AMM_IDX_MUTE_MASK = 12'h824;
	localparam logic [11:0] AMM_IDX_FUSE_STAT = 12'h900;
	localparam logic [11:0] AMM_IDX_POS_CTRL = 12'hB02;
	localparam logic [11:0] AMM_IDX_POS_REC = 12'hB03;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] AMM_RST_ALARM_OUTPUT_MASK = 8'h00;
	localparam logic [7:0] AMM_RST_MUTE_MASK = 8'h07;
	localparam logic [7:0] AMM_RST_POS_CTRL = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Field positions in both mask registers, trigger and clock bits also in the system alarm register; then position enable, fuse done and strobe lane
	localparam int AMM_BIT_FIFO = 7;
	localparam int AMM_BIT_IFCLK = 6;
	localparam int AMM_BIT_STROBE = 5;
	localparam int AMM_BIT_TRIG = 2;
	localparam int AMM_BIT_MISALIGN = 1;
	localparam int AMM_BIT_REALIGN = 0;
	localparam int AMM_BIT_POS_EN = 0;
	localparam int AMM_BIT_FUSE_DONE = 0;
	localparam int AMM_STRB_LANE = 0;

	// Silicon version that carries the accumulate function
	localparam logic [3:0] AMM_PS_CHIP_VERSION = 4'h2;

endpackage

// ---- hdl/amm_sticky.sv ----
// Sticky alarm bits: hardware sets, software clears by writing one
`timescale 1ns/10ps
`default_nettype none

module amm_sticky #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Set and clear strobes
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	// Latched bits
	output logic [W-1:0] bits_o
);

	typedef struct packed {
		logic [W-1:0] bits;
	} amm_sticky_state_t;

	amm_sticky_state_t state_q;
	amm_sticky_state_t state_d;

	////////////////////////////////////////////////////////////////////////////
	// Clear first, then set, so an alarm in the clearing cycle survives
	always_comb begin
		state_d = state_q;
		state_d.bits = (state_q.bits & ~clr_i) | set_i;
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign bits_o = state_q.bits;

endmodule
`default_nettype wire

// ---- hdl/amm_pos_record.sv ----
// Sync edge position record, latest edge or accumulated over edges
`timescale 1ns/10ps
`default_nettype none

module amm_pos_record #(
	parameter int POS_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Control
	input wire logic accum_en_i,
	// Detected edge and positions near it
	input wire logic edge_i,
	input wire logic [POS_W-1:0] near_i,
	// Record
	output logic [POS_W-1:0] record_o
);

	typedef struct packed {
		logic [POS_W-1:0] record;
		logic accum_prev;
	} amm_pos_state_t;

	amm_pos_state_t state_q;
	amm_pos_state_t state_d;
	logic [POS_W-1:0] base;

	////////////////////////////////////////////////////////////////////////////
	// Accumulation restarts when enable rises; otherwise latest edge only
	always_comb begin
		state_d = state_q;
		state_d.accum_prev = accum_en_i;
		base = state_q.record;
		if (accum_en_i && !state_q.accum_prev) begin
			base = '0;
		end
		state_d.record = base;
		if (edge_i) begin
			if (accum_en_i) begin
				state_d.record = base | near_i;
			end else begin
				state_d.record = near_i;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign record_o = state_q.record;

endmodule
`default_nettype wire

// ---- testbench/amm_bank_props.sv ----
// Port checker for the alarm and mute mask register bank
`timescale 1ns/10ps
`default_nettype none

module amm_bank_props (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register bus
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [amm_pkg::AMM_ADDR_W-1:0] paddr_i,
	input wire logic [amm_pkg::AMM_DATA_W-1:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Alarm sources and status
	input wire logic [amm_pkg::AMM_BANKS-1:0] fifo_enable_i,
	input wire logic [amm_pkg::AMM_BANKS-1:0] fifo_almost_empty_i,
	input wire logic [amm_pkg::AMM_BANKS-1:0] fifo_almost_full_i,
	input wire logic [amm_pkg::AMM_BANKS-1:0] iface_clock_missing_i,
	input wire logic [amm_pkg::AMM_BANKS-1:0] strobe_position_err_i,
	input wire logic trigger_divider_realign_i,
	input wire logic clock_misalignment_i,
	input wire logic clock_realignment_i,
	input wire logic fuse_done_i,
	// Outputs
	input wire logic alarm_o,
	input wire logic dac_mute_o
);
	import amm_pkg::*;

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// Any source that can set a latched alarm this cycle
	logic src_any;
	assign src_any = |(fifo_enable_i & (fifo_almost_empty_i | fifo_almost_full_i)) | |iface_clock_missing_i
		| |strobe_position_err_i | trigger_divider_realign_i | clock_misalignment_i | clock_realignment_i;

	////////////////////////////////////////////////////////////////////////////
	// Bus phases
	sequence s_first_access;
		psel_i && penable_i && !pready_o;
	endsequence
	sequence s_fuse_read;
		pready_o && psel_i && !pwrite_i && paddr_i[13:2] == AMM_IDX_FUSE_STAT && $stable(fuse_done_i);
	endsequence

	a_ready_wait: assert property (s_first_access |=> pready_o) else $error("ready late");
	a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
	a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
	a_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data idle");
	a_fuse_read: assert property (s_fuse_read |-> prdata_o[7:0] == {7'h00, fuse_done_i})
		else $error("fuse status wrong");
	// Outputs change two edges after a source or a completed write (latch, then output register)
	a_alarm_rise: assert property ($rose(alarm_o) |-> $past(src_any || (pready_o && pwrite_i), 2))
		else $error("alarm rose without cause");
	a_alarm_fall: assert property ($fell(alarm_o) |-> $past(pready_o && pwrite_i, 2))
		else $error("alarm fell without write");
	a_mute_rise: assert property ($rose(dac_mute_o) |-> $past(src_any || (pready_o && pwrite_i), 2))
		else $error("mute rose without cause");
	a_mute_fall: assert property ($fell(dac_mute_o) |-> $past(pready_o && pwrite_i, 2))
		else $error("mute fell without write");
endmodule

bind amm_bank amm_bank_props amm_bank_props_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .fifo_enable_i(fifo_enable_i), .fifo_almost_empty_i(fifo_almost_empty_i),
	.fifo_almost_full_i(fifo_almost_full_i), .iface_clock_missing_i(iface_clock_missing_i),
	.strobe_position_err_i(strobe_position_err_i), .trigger_divider_realign_i(trigger_divider_realign_i),
	.clock_misalignment_i(clock_misalignment_i), .clock_realignment_i(clock_realignment_i),
	.fuse_done_i(fuse_done_i), .alarm_o(alarm_o), .dac_mute_o(dac_mute_o));

`default_nettype wire

// ---- testbench/amm_bank_tb.sv ----
// Self-checking bench for the alarm and mute mask register bank
`timescale 1ns/10ps
`default_nettype none

module amm_bank_tb;
	import amm_pkg::*;

	logic clk_i = 1'b0, sys_rst_i = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, err, alm, mute;
	logic [13:0] addr = '0;
	logic [31:0] wdat = '0, rdat, rd;
	logic [3:0] strb = 4'hF, fen = '0, fae = '0, faf = '0, ifc = '0, stb = '0, ver = 4'h2;
	logic trg = 1'b0, mis = 1'b0, rea = 1'b0, fuse = 1'b0, sedge = 1'b0, er;
	logic [7:0] near = '0, am, mm, pa, pb;
	int mismatches = 0, samples_checked = 0, k, b;
	int mb[6] = '{7, 6, 5, 2, 1, 0};
	logic [11:0] ri[6] = '{AMM_IDX_FIFO_LEVEL_ALARM_BITS, AMM_IDX_LINK_ALM, AMM_IDX_LINK_ALM, AMM_IDX_SYS_ALM,
		AMM_IDX_SYS_ALM, AMM_IDX_SYS_ALM};

	// Clock
	always #5 clk_i = ~clk_i;

	amm_bank amm_bank_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(addr), .pwdata_i(wdat), .pstrb_i(strb), .prdata_o(rdat), .pready_o(rdy), .pslverr_o(err),
		.fifo_enable_i(fen), .fifo_almost_empty_i(fae), .fifo_almost_full_i(faf), .iface_clock_missing_i(ifc),
		.strobe_position_err_i(stb), .trigger_divider_realign_i(trg), .clock_misalignment_i(mis),
		.clock_realignment_i(rea), .fuse_done_i(fuse), .chip_version_i(ver), .sync_edge_i(sedge),
		.sync_near_i(near), .alarm_o(alm), .dac_mute_o(mute));

	////////////////////////////////////////////////////////////////////////////
	// Bus, compare and stimulus tasks
	task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] wd);
		@(posedge clk_i);
		psel <= 1'b1;
		pwr <= w;
		addr <= {idx, 2'b00};
		wdat <= {24'($urandom), wd};
		@(posedge clk_i);
		pen <= 1'b1;
		// Wait for ready; only the watchdog ends a hung wait
		do begin
			@(posedge clk_i);
		end while (rdy !== 1'b1);
		rd = rdat;
		er = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rdchk(input logic [11:0] idx, input logic [7:0] e, input string nm);
		apb(1'b0, idx, 8'h00);
		chk(nm, {24'h0, e}, rd);
	endtask

	task automatic do_reset();
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
	endtask

	// One-cycle alarm event, then wait for the outputs to follow
	task automatic pulse(input int k, input int bn);
		logic [3:0] e;
		e = 4'($urandom) | (4'h1 << bn);
		@(posedge clk_i);
		case (k)
			0: begin
				fen <= e;
				fae <= ~e;
				faf <= 4'h1 << bn;
			end
			1: ifc <= 4'h1 << bn;
			2: stb <= 4'h1 << bn;
			3: trg <= 1'b1;
			4: mis <= 1'b1;
			default: rea <= 1'b1;
		endcase
		@(posedge clk_i);
		{fae, faf, ifc, stb} <= '0;
		{trg, mis, rea} <= '0;
		repeat (2) @(posedge clk_i);
	endtask

	task automatic edge_in(input logic [7:0] p);
		@(posedge clk_i);
		sedge <= 1'b1;
		near <= p;
		@(posedge clk_i);
		sedge <= 1'b0;
		near <= ~p;
	endtask

	function automatic logic [7:0] exp_lat(input int k, input int bn);
		case (k)
			0, 2: exp_lat = 8'h01 << bn;
			1: exp_lat = 8'h10 << bn;
			default: exp_lat = 8'h01 << (5 - k);
		endcase
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		#100000;
		mismatches++;
		stop_test();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h2100));
		do_reset();
		rdchk(AMM_IDX_ALARM_OUTPUT_MASK, 8'h00, "alarm mask reset");
		rdchk(AMM_IDX_MUTE_MASK, 8'h07, "mute mask reset");
		rdchk(AMM_IDX_POS_CTRL, 8'h00, "pos ctrl reset");
		rdchk(AMM_IDX_FUSE_STAT, 8'h00, "fuse before load");
		fuse <= 1'b1;
		apb(1'b1, AMM_IDX_FUSE_STAT, 8'hFE);
		rdchk(AMM_IDX_FUSE_STAT, 8'h01, "fuse after load");
		apb(1'b0, 12'h123, 8'h00);
		chk("unmapped error", 32'h1, {31'h0, er});
		strb <= 4'h0;
		apb(1'b1, AMM_IDX_ALARM_OUTPUT_MASK, 8'hFF);
		strb <= 4'hF;
		rdchk(AMM_IDX_ALARM_OUTPUT_MASK, 8'h00, "strobe off write");
		// Every source, first with the reset masks, then against random alarm and mute masks
		for (int i = 0; i < 24; i++) begin
			k = i % 6;
			b = $urandom_range(3, 0);
			am = (i < 6) ? 8'h00 : 8'($urandom);
			mm = (i < 6) ? 8'h07 : 8'($urandom);
			apb(1'b1, AMM_IDX_ALARM_OUTPUT_MASK, am);
			apb(1'b1, AMM_IDX_MUTE_MASK, mm);
			rdchk(AMM_IDX_ALARM_OUTPUT_MASK, am, "alarm mask rw");
			pulse(k, b);
			chk("alarm", {31'h0, ~am[mb[k]]}, {31'h0, alm});
			chk("mute", {31'h0, ~mm[mb[k]]}, {31'h0, mute});
			rdchk(ri[k], exp_lat(k, b), "latched alarm");
			apb(1'b1, ri[k], exp_lat(k, b));
			rdchk(ri[k], 8'h00, "cleared alarm");
			chk("alarm cleared", 32'h0, {31'h0, alm});
			chk("mute cleared", 32'h0, {31'h0, mute});
		end
		// Position record: latest, accumulated, then other silicon
		pa = 8'($urandom);
		pb = 8'($urandom);
		apb(1'b1, AMM_IDX_POS_CTRL, 8'h00);
		edge_in(pa);
		edge_in(pb);
		rdchk(AMM_IDX_POS_REC, pb, "record latest");
		apb(1'b1, AMM_IDX_POS_CTRL, 8'h01);
		edge_in(pa);
		edge_in(pb);
		rdchk(AMM_IDX_POS_REC, pa | pb, "record accumulated");
		ver <= 4'h3;
		edge_in(pb);
		edge_in(pa);
		rdchk(AMM_IDX_POS_REC, pa, "record other version");
		// Reset in mid-run restores masks
		apb(1'b1, AMM_IDX_MUTE_MASK, 8'h00);
		do_reset();
		rdchk(AMM_IDX_MUTE_MASK, 8'h07, "mute mask second reset");
		stop_test();
	end
endmodule

`default_nettype wire
